/* File: src/twr_pkg.sv */
package twr_pkg;

	// register space seen through the serial pointer
	localparam int unsigned REG_COUNT = 128;
	localparam int unsigned PTR_W = 7;
	localparam logic [6:0] PTR_MAX = 7'h7f;
	localparam logic [6:0] PTR_RESET = 7'h00;
	localparam int unsigned HOLD_BIT = 7;

	// port control register and its pass-through field
	localparam logic [6:0] PORT_CTRL_OFS = 7'h14;
	localparam int unsigned PASS_BIT = 6;
	localparam logic [7:0] PORT_CTRL_RST = 8'h20;

	// read-only test readback register
	localparam logic [6:0] TEST_RB_OFS = 7'h6b;
	localparam logic [7:0] TEST_RB_RST = 8'h00;

	// every other storage register
	localparam logic [7:0] REG_RST = 8'h00;

	// serial framing
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	// cycles a bridge direction stays blocked after the other one lets go
	localparam logic [2:0] BRIDGE_GUARD = 3'h5;

	typedef struct packed {
		logic scl;
		logic sda;
		logic tuner_sda;
	} twr_lines_t;

	typedef struct packed {
		logic en;
		logic [6:0] addr;
		logic [7:0] data;
	} twr_wr_t;

	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_ADDR = 7'h02,
		ST_ADDR_ACK = 7'h04,
		ST_WR_BYTE = 7'h08,
		ST_WR_ACK = 7'h10,
		ST_RD_BYTE = 7'h20,
		ST_RD_ACK = 7'h40
	} twr_state_t;

	// pointer step after a data byte: held, or +1 saturating at the top
	function automatic logic [6:0] twr_next_ptr(input logic [6:0] p,
		input logic hold);
		logic [6:0] n;
		n = p;
		if (!hold && p != PTR_MAX)
		begin
			n = p + 7'h01;
		end
		return n;
	endfunction : twr_next_ptr

endpackage : twr_pkg

/* File: src/twr_sync.sv */
`timescale 1ns/1ps
module twr_sync import twr_pkg::*; #(
	parameter int unsigned WIDTH = 3,
	parameter logic [WIDTH-1:0] RST_VAL = '1
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// asynchronous lines and their filtered copies
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] stable_out
);

	if (WIDTH < 1)
	begin : g_bad_width
		$error("twr_sync: WIDTH must be at least one");
	end

	logic [WIDTH-1:0] s1_q, s2_q, s3_q, stable_q;
	logic [WIDTH-1:0] stable_d;

	// a bit moves only when stages two and three agree, so a glitch
	// shorter than a clock never reaches the protocol logic
	always_comb
	begin
		stable_d = stable_q;
		for (int i = 0; i < WIDTH; i++)
		begin
			if (s2_q[i] == s3_q[i])
			begin
				stable_d[i] = s3_q[i];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s1_q <= RST_VAL;
			s2_q <= RST_VAL;
			s3_q <= RST_VAL;
			stable_q <= RST_VAL;
		end
		else
		begin
			s1_q <= async_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			stable_q <= stable_d;
		end
	end

	assign stable_out = stable_q;

endmodule : twr_sync

/* File: src/twr_regs.sv */
`timescale 1ns/1ps
module twr_regs import twr_pkg::*; #(
	parameter int unsigned DEPTH = REG_COUNT
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// write and read ports
	input wire twr_wr_t wr,
	input wire logic [6:0] raddr,
	output logic [7:0] rdata,
	// decoded control
	output logic pass_through
);

	if (DEPTH != REG_COUNT)
	begin : g_bad_depth
		$error("twr_regs: DEPTH must match the 7-bit pointer range");
	end

	logic [7:0] mem_q [DEPTH];
	logic [7:0] mem_d [DEPTH];

	always_comb
	begin
		mem_d = mem_q;
		// the test readback register ignores writes
		if (wr.en && wr.addr != TEST_RB_OFS)
		begin
			mem_d[wr.addr] = wr.data;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < DEPTH; i++)
			begin
				mem_q[i] <= REG_RST;
			end
			mem_q[PORT_CTRL_OFS] <= PORT_CTRL_RST;
			mem_q[TEST_RB_OFS] <= TEST_RB_RST;
		end
		else
		begin
			mem_q <= mem_d;
		end
	end

	assign rdata = mem_q[raddr];
	// bit 6 of port control opens the tuner path
	assign pass_through = mem_q[PORT_CTRL_OFS][PASS_BIT];

endmodule : twr_regs

/* File: src/twr_slave.sv */
// What this block does
// - in a write not preceded by a read, first byte after chip address loads the pointer only
// - a read after STOP starts returning register zero
// - STOP after a valid chip address clears the pointer to zero
// - START or repeated START leaves the pointer untouched
// - pointer bit 7 high holds the pointer, low advances it per byte
// - low seven pointer bits select register 0 to 127
// - auto-increment stops at 127 and stays until STOP or a new pointer byte
// - bytes travel most significant bit first both ways
// - address bit eight high means slave transmitter, low receiver
// - straps are caught at reset release as the 7-bit bus address
// - foreign chip addresses are ignored until our own comes again
// - write after read by repeated START continues at current pointer
// - port control bit 6 opens or closes the tuner pass-through
// - pass-through carries clock on port line 0, data on line 1
// - test readback register ignores writes and resets to zero
`timescale 1ns/1ps
module twr_slave import twr_pkg::*; (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// address straps
	input wire logic [6:0] addr_strap,
	// host serial bus
	input wire logic host_bus_clock,
	input wire logic host_bus_data_i,
	output logic host_bus_data_o,
	output logic host_bus_data_oe,
	// tuner bus on general port lines 0 and 1
	output logic tuner_bus_clock_o,
	output logic tuner_bus_clock_oe,
	input wire logic tuner_bus_data_i,
	output logic tuner_bus_data_o,
	output logic tuner_bus_data_oe,
	// status
	output logic pass_through
);

	// ---------------- pin synchronisers
	twr_lines_t lines_raw;
	twr_lines_t lines;
	logic [2:0] lines_vec;

	assign lines_raw = '{scl: host_bus_clock, sda: host_bus_data_i,
		tuner_sda: tuner_bus_data_i};

	twr_sync #(
		.WIDTH(3),
		.RST_VAL(3'h7)
	) u_sync (
		.clk(ref_clk),
		.rst_n(rst_n),
		.async_in(lines_raw),
		.stable_out(lines_vec)
	);

	assign lines = twr_lines_t'(lines_vec);

	// ---------------- strap capture
	logic [6:0] bus_addr_q, bus_addr_d;
	logic strap_done_q, strap_done_d;

	// straps are static wiring, so the first edge after release takes
	// them directly; the value then holds until the next reset
	always_comb
	begin
		bus_addr_d = bus_addr_q;
		strap_done_d = strap_done_q;
		if (!strap_done_q)
		begin
			bus_addr_d = addr_strap;
			strap_done_d = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bus_addr_q <= 7'h00;
			strap_done_q <= 1'b0;
		end
		else
		begin
			bus_addr_q <= bus_addr_d;
			strap_done_q <= strap_done_d;
		end
	end

	// ---------------- register file
	twr_wr_t wr_d;
	logic [6:0] ptr_q, ptr_d;
	logic [7:0] rd_data;
	logic pass_en;

	twr_regs #(
		.DEPTH(REG_COUNT)
	) u_regs (
		.clk(ref_clk),
		.rst_n(rst_n),
		.wr(wr_d),
		.raddr(ptr_q),
		.rdata(rd_data),
		.pass_through(pass_en)
	);

	// ---------------- bus conditions
	logic scl_p_q, sda_p_q;
	logic scl_rise, scl_fall, bus_start, bus_stop;

	assign scl_rise = lines.scl & ~scl_p_q;
	assign scl_fall = ~lines.scl & scl_p_q;
	assign bus_start = lines.scl & scl_p_q & ~lines.sda & sda_p_q;
	assign bus_stop = lines.scl & scl_p_q & lines.sda & ~sda_p_q;

	// ---------------- protocol engine
	twr_state_t st_q, st_d;
	logic [3:0] cnt_q, cnt_d;
	logic [7:0] sh_q, sh_d;
	logic hold_q, hold_d;
	logic first_q, first_d;
	logic addressed_q, addressed_d;
	logic rd_seen_q, rd_seen_d;
	logic rw_q, rw_d;
	logic drv_q, drv_d;
	logic nack_q, nack_d;

	always_comb
	begin
		st_d = st_q;
		cnt_d = cnt_q;
		sh_d = sh_q;
		ptr_d = ptr_q;
		hold_d = hold_q;
		first_d = first_q;
		addressed_d = addressed_q;
		rd_seen_d = rd_seen_q;
		rw_d = rw_q;
		drv_d = drv_q;
		nack_d = nack_q;
		wr_d = '0;
		if (bus_stop)
		begin
			if (addressed_q)
			begin
				ptr_d = PTR_RESET;
				hold_d = 1'b0;
			end
			addressed_d = 1'b0;
			rd_seen_d = 1'b0;
			drv_d = 1'b0;
			st_d = ST_IDLE;
		end
		else if (bus_start)
		begin
			// pointer and hold flag survive a repeated start
			cnt_d = 4'h0;
			drv_d = 1'b0;
			st_d = ST_ADDR;
		end
		else
		begin
			case (st_q)
				ST_IDLE:
				begin
					drv_d = 1'b0;
				end
				ST_ADDR:
				begin
					if (scl_rise)
					begin
						sh_d = {sh_q[6:0], lines.sda};
						cnt_d = cnt_q + 4'h1;
					end
					else if (scl_fall && cnt_q == BITS_PER_BYTE)
					begin
						if (sh_q[7:1] == bus_addr_q)
						begin
							drv_d = 1'b1;
							rw_d = sh_q[0];
							addressed_d = 1'b1;
							st_d = ST_ADDR_ACK;
						end
						else
						begin
							st_d = ST_IDLE;
						end
					end
				end
				ST_ADDR_ACK:
				begin
					if (scl_fall)
					begin
						cnt_d = 4'h0;
						if (rw_q)
						begin
							// after a stop the pointer is zero
							sh_d = rd_data;
							drv_d = ~rd_data[7];
							rd_seen_d = 1'b1;
							st_d = ST_RD_BYTE;
						end
						else
						begin
							drv_d = 1'b0;
							// no pointer byte after a read
							first_d = ~rd_seen_q;
							st_d = ST_WR_BYTE;
						end
					end
				end
				ST_WR_BYTE:
				begin
					if (scl_rise)
					begin
						sh_d = {sh_q[6:0], lines.sda};
						cnt_d = cnt_q + 4'h1;
					end
					else if (scl_fall && cnt_q == BITS_PER_BYTE)
					begin
						if (first_q)
						begin
							ptr_d = sh_q[6:0];
							hold_d = sh_q[HOLD_BIT];
							first_d = 1'b0;
						end
						else
						begin
							wr_d = '{en: 1'b1, addr: ptr_q, data: sh_q};
							ptr_d = twr_next_ptr(ptr_q, hold_q);
						end
						drv_d = 1'b1;
						st_d = ST_WR_ACK;
					end
				end
				ST_WR_ACK:
				begin
					if (scl_fall)
					begin
						drv_d = 1'b0;
						cnt_d = 4'h0;
						st_d = ST_WR_BYTE;
					end
				end
				ST_RD_BYTE:
				begin
					if (scl_rise)
					begin
						cnt_d = cnt_q + 4'h1;
					end
					else if (scl_fall)
					begin
						if (cnt_q == BITS_PER_BYTE)
						begin
							drv_d = 1'b0;
							ptr_d = twr_next_ptr(ptr_q, hold_q);
							st_d = ST_RD_ACK;
						end
						else if (cnt_q != 4'h0)
						begin
							sh_d = {sh_q[6:0], 1'b0};
							drv_d = ~sh_q[6];
						end
					end
				end
				ST_RD_ACK:
				begin
					if (scl_rise)
					begin
						nack_d = lines.sda;
					end
					else if (scl_fall)
					begin
						if (!nack_q)
						begin
							sh_d = rd_data;
							drv_d = ~rd_data[7];
							cnt_d = 4'h0;
							st_d = ST_RD_BYTE;
						end
						else
						begin
							// host ended the read; wait for stop or restart
							st_d = ST_IDLE;
						end
					end
				end
				default:
				begin
					drv_d = 1'b0;
					st_d = ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
			st_q <= ST_IDLE;
			cnt_q <= 4'h0;
			sh_q <= 8'h00;
			ptr_q <= PTR_RESET;
			hold_q <= 1'b0;
			first_q <= 1'b0;
			addressed_q <= 1'b0;
			rd_seen_q <= 1'b0;
			rw_q <= 1'b0;
			drv_q <= 1'b0;
			nack_q <= 1'b0;
		end
		else
		begin
			scl_p_q <= lines.scl;
			sda_p_q <= lines.sda;
			st_q <= st_d;
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			ptr_q <= ptr_d;
			hold_q <= hold_d;
			first_q <= first_d;
			addressed_q <= addressed_d;
			rd_seen_q <= rd_seen_d;
			rw_q <= rw_d;
			drv_q <= drv_d;
			nack_q <= nack_d;
		end
	end

	// ---------------- pass-through bridge and pin drivers
	// each data direction may only start while the other is idle and the
	// guard has run out; the guard covers the synchroniser lag, without
	// it both sides would keep each other low after a release
	logic to_host_q, to_host_d;
	logic to_tuner_q, to_tuner_d;
	logic [2:0] guard_q, guard_d;
	logic tclk_oe_q, tclk_oe_d;
	logic host_oe_q, host_oe_d;
	logic pass_q;

	always_comb
	begin
		tclk_oe_d = pass_en & ~lines.scl;
		to_host_d = pass_en & ~lines.tuner_sda & ~to_tuner_q &
			(to_host_q | guard_q == 3'h0);
		to_tuner_d = pass_en & ~lines.sda & ~to_host_q & ~drv_q &
			(to_tuner_q | guard_q == 3'h0);
		host_oe_d = drv_d | to_host_d;
		guard_d = guard_q;
		// any release of the host line, our own acknowledge included,
		// starts the guard so its lagging low does not leak to the tuner
		if ((host_oe_q & ~host_oe_d) | (to_tuner_q & ~to_tuner_d))
		begin
			guard_d = BRIDGE_GUARD;
		end
		else if (guard_q != 3'h0)
		begin
			guard_d = guard_q - 3'h1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			to_host_q <= 1'b0;
			to_tuner_q <= 1'b0;
			guard_q <= 3'h0;
			tclk_oe_q <= 1'b0;
			host_oe_q <= 1'b0;
			pass_q <= 1'b0;
		end
		else
		begin
			to_host_q <= to_host_d;
			to_tuner_q <= to_tuner_d;
			guard_q <= guard_d;
			tclk_oe_q <= tclk_oe_d;
			host_oe_q <= host_oe_d;
			pass_q <= pass_en;
		end
	end

	// open-drain pins only ever pull low
	assign host_bus_data_o = 1'b0;
	assign tuner_bus_clock_o = 1'b0;
	assign tuner_bus_data_o = 1'b0;
	assign host_bus_data_oe = host_oe_q;
	assign tuner_bus_clock_oe = tclk_oe_q;
	assign tuner_bus_data_oe = to_tuner_q;
	assign pass_through = pass_q;

endmodule : twr_slave

/* File: test/twr_slave_asserts.sv */
`timescale 1ns/1ps
module twr_slave_asserts (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// host bus
	input wire logic host_bus_clock,
	input wire logic host_bus_data_i,
	input wire logic host_bus_data_o,
	input wire logic host_bus_data_oe,
	// tuner bus and status
	input wire logic tuner_bus_clock_o,
	input wire logic tuner_bus_clock_oe,
	input wire logic tuner_bus_data_o,
	input wire logic tuner_bus_data_oe,
	input wire logic pass_through
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	a_reset_quiet: assert property (
		$rose(rst_n) |-> !host_bus_data_oe && !pass_through)
		else $error("outputs active right after reset");
	a_open_drain: assert property (
		!host_bus_data_o && !tuner_bus_clock_o && !tuner_bus_data_o)
		else $error("open drain value not low");
	a_change_scl_low: assert property (
		$changed(host_bus_data_oe) |-> !host_bus_clock)
		else $error("data drive changed while clock high");
	a_oe_hold: assert property (
		$rose(host_bus_data_oe) |=> host_bus_data_oe[*3])
		else $error("data drive too short");
	a_tuner_closed: assert property (
		!pass_through[*8] |-> !tuner_bus_clock_oe && !tuner_bus_data_oe)
		else $error("tuner bus driven while closed");
	a_clk_mirror: assert property (
		(pass_through && !host_bus_clock)[*6] |-> tuner_bus_clock_oe)
		else $error("tuner clock not following low");
	a_clk_free: assert property (
		(pass_through && host_bus_clock)[*6] |-> !tuner_bus_clock_oe)
		else $error("tuner clock held low");
	a_data_follow: assert property (
		(pass_through && !host_bus_data_oe && !host_bus_data_i)[*6] |->
		tuner_bus_data_oe)
		else $error("tuner data not following low");

	c_pass: cover property ($rose(pass_through));
	c_ack: cover property ($rose(host_bus_data_oe));
	c_tuner: cover property ($rose(tuner_bus_clock_oe));
endmodule : twr_slave_asserts

bind twr_slave twr_slave_asserts chk (
	.ref_clk(ref_clk), .rst_n(rst_n), .host_bus_clock(host_bus_clock),
	.host_bus_data_i(host_bus_data_i), .host_bus_data_o(host_bus_data_o),
	.host_bus_data_oe(host_bus_data_oe),
	.tuner_bus_clock_o(tuner_bus_clock_o),
	.tuner_bus_clock_oe(tuner_bus_clock_oe),
	.tuner_bus_data_o(tuner_bus_data_o),
	.tuner_bus_data_oe(tuner_bus_data_oe), .pass_through(pass_through));

/* File: test/twr_host.sv */
`timescale 1ns/1ps
module twr_host (
	// link clock
	input wire logic lclk,
	// bus wires
	input wire logic sda,
	output logic scl,
	output logic sda_oe
);
	// 25 link ticks keep each clock phase above the 500 ns the slave needs
	localparam int PH = 25;
	initial
	begin
		scl = 1'b1;
		sda_oe = 1'b0;
	end
	task automatic ph();
		repeat (PH) @(posedge lclk);
	endtask : ph
	// data moves mid low phase, line is read at the end of the high phase
	task automatic bit_io(input logic b, output logic r);
		scl <= 1'b0;
		ph();
		sda_oe <= !b;
		ph();
		scl <= 1'b1;
		ph();
		r = sda;
	endtask : bit_io
	// start is cond(0,1), stop is cond(1,0)
	task automatic cond(input logic a, input logic b);
		@(posedge lclk);
		scl <= 1'b0;
		ph();
		sda_oe <= a;
		ph();
		scl <= 1'b1;
		ph();
		sda_oe <= b;
		ph();
	endtask : cond
	task automatic xfer(input logic [7:0] tx, input logic last,
		output logic [7:0] rx, output logic ack);
		for (int i = 7; i >= 0; i--)
		begin
			bit_io(tx[i], rx[i]);
		end
		bit_io(last, ack);
	endtask : xfer
	// parks the clock low between frames so the far side may move data, or high again when low is clear
	task automatic park(input logic low);
		@(posedge lclk);
		scl <= !low;
		ph();
	endtask : park
endmodule : twr_host

/* File: test/twr_slave_bench.sv */
`timescale 1ns/1ps
module twr_slave_bench import twr_pkg::*; ();
	typedef struct packed {
		logic [7:0] ptr;
		logic [7:0] dat;
		logic [7:0] exp;
	} twr_row_t;
	localparam logic [7:0] WR = 8'h1c;
	localparam logic [7:0] RD = 8'h1d;
	logic ref_clk = 1'b0;
	logic lclk = 1'b0;
	logic rst_n = 1'b0;
	logic [6:0] strap = 7'h0e;
	logic scl, h_oe, oe, tc_oe, td_oe, pass, a, sda;
	logic [7:0] rx;
	logic tuner_pull = 1'b0;
	int bad_count = 0;
	int checks = 0;
	int cyc = 0;
	twr_row_t rows [4] = '{
		'{8'h05, 8'ha5, 8'ha5},
		'{{1'b0, TEST_RB_OFS}, 8'h5a, TEST_RB_RST},
		'{{1'b0, PORT_CTRL_OFS}, 8'h40, 8'h40},
		'{{1'b0, PORT_CTRL_OFS}, 8'h00, 8'h00}};

	assign sda = !(h_oe | oe);
	always #50 ref_clk = !ref_clk;
	always #16 lclk = !lclk;

	twr_slave dut (
		.ref_clk(ref_clk), .rst_n(rst_n), .addr_strap(strap),
		.host_bus_clock(scl), .host_bus_data_i(sda),
		.host_bus_data_o(), .host_bus_data_oe(oe),
		.tuner_bus_clock_o(), .tuner_bus_clock_oe(tc_oe),
		.tuner_bus_data_i(!(td_oe | tuner_pull)), .tuner_bus_data_o(),
		.tuner_bus_data_oe(td_oe), .pass_through(pass));
	twr_host host (.lclk(lclk), .sda(sda), .scl(scl), .sda_oe(h_oe));

	task automatic stop_test();
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : stop_test
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask : chk8
	task automatic put(input logic [7:0] b);
		host.xfer(b, 1'b1, rx, a);
		chk8({7'h00, a}, 8'h00);
	endtask : put
	task automatic get(input logic last, input logic [7:0] e);
		host.xfer(8'hff, last, rx, a);
		chk8(rx, e);
	endtask : get
	task automatic wr_at(input logic [7:0] p, input logic [7:0] d);
		host.cond(1'b0, 1'b1);
		put(WR);
		put(p);
		put(d);
		host.cond(1'b1, 1'b0);
	endtask : wr_at
	task automatic rd_at(input logic [7:0] p, input logic [7:0] e);
		host.cond(1'b0, 1'b1);
		put(WR);
		put(p);
		host.cond(1'b0, 1'b1);
		put(RD);
		get(1'b1, e);
		host.cond(1'b1, 1'b0);
	endtask : rd_at

	always @(posedge ref_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 40000)
		begin
			bad_count++;
			stop_test();
		end
	end

	initial
	begin
		repeat (5) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (10) @(posedge ref_clk);
		foreach (rows[i])
		begin
			wr_at(rows[i].ptr, rows[i].dat);
			rd_at(rows[i].ptr, rows[i].exp);
			if (rows[i].ptr == {1'b0, PORT_CTRL_OFS})
				chk8({7'h00, pass},
					{7'h00, rows[i].dat[PASS_BIT]});
		end
		// tuner pulls its data low through the open path, clock parked low
		wr_at({1'b0, PORT_CTRL_OFS}, 8'h40);
		host.park(1'b1);
		@(posedge ref_clk);
		tuner_pull <= 1'b1;
		repeat (12) @(posedge ref_clk);
		chk8({7'h00, sda}, 8'h00);
		tuner_pull <= 1'b0;
		repeat (12) @(posedge ref_clk);
		chk8({7'h00, sda}, 8'h01);
		host.park(1'b0);
		wr_at({1'b0, PORT_CTRL_OFS}, 8'h00);
		wr_at(8'h00, 8'h77);
		host.cond(1'b0, 1'b1);
		host.xfer(8'h3c, 1'b1, rx, a);
		chk8({7'h00, a}, 8'h01);
		host.xfer(8'h00, 1'b1, rx, a);
		host.cond(1'b1, 1'b0);
		host.cond(1'b0, 1'b1);
		put(WR);
		put(8'h05);
		host.cond(1'b1, 1'b0);
		host.cond(1'b0, 1'b1);
		put(RD);
		get(1'b1, 8'h77);
		host.cond(1'b1, 1'b0);
		// top of the map: later bytes pile onto the last register
		host.cond(1'b0, 1'b1);
		put(WR);
		put(8'h7e);
		put(8'h11);
		put(8'h22);
		put(8'h33);
		host.cond(1'b0, 1'b1);
		put(RD);
		get(1'b1, 8'h33);
		host.cond(1'b0, 1'b1);
		put(WR);
		put(8'h44);
		host.cond(1'b1, 1'b0);
		rd_at(8'h7e, 8'h11);
		rd_at(8'h7f, 8'h44);
		host.cond(1'b0, 1'b1);
		put(WR);
		put(8'h90);
		put(8'h55);
		put(8'h66);
		host.cond(1'b1, 1'b0);
		rd_at(8'h10, 8'h66);
		rd_at(8'h11, 8'h00);
		@(posedge ref_clk);
		rst_n <= 1'b0;
		repeat (5) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		// straps moved after release must not change the address
		strap <= 7'h2a;
		repeat (10) @(posedge ref_clk);
		chk8({7'h00, pass}, 8'h00);
		rd_at({1'b0, PORT_CTRL_OFS}, PORT_CTRL_RST);
		rd_at({1'b0, TEST_RB_OFS}, TEST_RB_RST);
		rd_at(8'h00, REG_RST);
		stop_test();
	end
endmodule : twr_slave_bench
